// ---- tcs_pkg.sv ----
// =====================================================
// Shared constants of the ternary search engine
package tcs_pkg;
  // =====================================================
  // Geometry
  localparam int KEY_W = 40;
  localparam int VAL_W = 16;
  localparam int DEPTH = 16;
  localparam int IDX_W = 4;
  localparam int FIFO_DEPTH = 16;
  // =====================================================
  // Range-checked key sub-fields, fixed at build time
  localparam int RANGE_N = 2;
  localparam int RANGE_W = 8;
  localparam int RANGE0_OFF = 0;
  localparam int RANGE1_OFF = 8;
  // =====================================================
  // Storage option and update occupancy
  localparam bit USE_BLOCK_RAM = 1'b0;
  localparam int UPD_CYC_DIST = 33;
  localparam int UPD_CYC_BLOCK = 513;
  localparam int UPD_CNT_W = 10;
  localparam logic [UPD_CNT_W-1:0] UPD_LAST =
    UPD_CNT_W'(USE_BLOCK_RAM ? UPD_CYC_BLOCK - 1 : UPD_CYC_DIST - 1);
  // =====================================================
  // Update controller states
  typedef enum logic [1:0]
  {
    UPD_IDLE = 2'b00,
    UPD_DRAIN = 2'b01,
    UPD_BUSY = 2'b10
  } tcs_upd_state_t;
endpackage

// ---- tcs_fifo.sv ----
`timescale 1ns/1ns
`default_nettype none
// =====================================================
// Request queue: first word falls through to the output
module tcs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic push;
  logic pop;

  // Handshakes on both sides
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];

  // Occupancy
  always_comb
  begin
    cnt_d = cnt_q;
    if (push && !pop)
    begin
      cnt_d = cnt_q + 1'b1;
    end
    else if (pop && !push)
    begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // Pointers, count and registered ready; depth must be a power of two
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      in_ready_o <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_d;
      in_ready_o <= (cnt_d < (AW+1)'(DEPTH)); // Back-pressure reaches the source
    end
  end

  // Storage, no reset needed
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data_i;
    end
  end
endmodule
`default_nettype wire

// ---- tcs_search.sv ----
`timescale 1ns/1ns
`default_nettype none
// =====================================================
// Ternary search engine with update controller
module tcs_search (
  input wire logic clk_i,
  input wire logic rst_i,
  // Lookup side
  input wire logic search_request_strobe_i,
  input wire logic [tcs_pkg::KEY_W-1:0] search_request_key_i,
  output logic search_request_ready_o,
  output logic search_result_strobe_o,
  output logic search_hit_flag_o,
  output logic [tcs_pkg::KEY_W-1:0] search_result_key_copy_o,
  output logic [tcs_pkg::IDX_W-1:0] search_hit_index_o,
  output logic [tcs_pkg::VAL_W-1:0] search_hit_payload_o,
  // Software entry access
  input wire logic upd_req_i,
  input wire logic upd_write_i,
  input wire logic [tcs_pkg::IDX_W-1:0] upd_index_i,
  input wire logic upd_enable_i,
  input wire logic [tcs_pkg::KEY_W-1:0] upd_data_i,
  input wire logic [tcs_pkg::KEY_W-1:0] upd_mask_i,
  input wire logic [tcs_pkg::VAL_W-1:0] upd_value_i,
  output logic upd_busy_o,
  output logic upd_done_o,
  output logic upd_rd_enable_o,
  output logic [tcs_pkg::KEY_W-1:0] upd_rd_data_o,
  output logic [tcs_pkg::KEY_W-1:0] upd_rd_mask_o,
  output logic [tcs_pkg::VAL_W-1:0] upd_rd_value_o
);
  // =====================================================
  // Helpers

  // True when bit b lies inside a range-checked sub-field
  function automatic logic in_range_field(input int b);
    logic r;
    r = 1'b0;
    if (tcs_pkg::RANGE_N > 0 && b >= tcs_pkg::RANGE0_OFF && b < tcs_pkg::RANGE0_OFF + tcs_pkg::RANGE_W)
    begin
      r = 1'b1;
    end
    if (tcs_pkg::RANGE_N > 1 && b >= tcs_pkg::RANGE1_OFF && b < tcs_pkg::RANGE1_OFF + tcs_pkg::RANGE_W)
    begin
      r = 1'b1;
    end
    return r;
  endfunction

  // Inclusive numeric window; data holds min, mask holds max
  function automatic logic range_ok(
    input logic [tcs_pkg::RANGE_W-1:0] k,
    input logic [tcs_pkg::RANGE_W-1:0] lo,
    input logic [tcs_pkg::RANGE_W-1:0] hi
  );
    return (k >= lo) && (k <= hi);
  endfunction

  // One entry against one key
  function automatic logic entry_hit(
    input logic [tcs_pkg::KEY_W-1:0] key,
    input logic [tcs_pkg::KEY_W-1:0] data,
    input logic [tcs_pkg::KEY_W-1:0] mask
  );
    logic ok;
    ok = 1'b1;
    for (int b = 0; b < tcs_pkg::KEY_W; b++)
    begin
      if (!in_range_field(b) && mask[b] && (key[b] != data[b]))
      begin
        ok = 1'b0;
      end
    end
    if (tcs_pkg::RANGE_N > 0)
    begin
      ok = ok && range_ok(key[tcs_pkg::RANGE0_OFF +: tcs_pkg::RANGE_W],
        data[tcs_pkg::RANGE0_OFF +: tcs_pkg::RANGE_W],
        mask[tcs_pkg::RANGE0_OFF +: tcs_pkg::RANGE_W]);
    end
    if (tcs_pkg::RANGE_N > 1)
    begin
      ok = ok && range_ok(key[tcs_pkg::RANGE1_OFF +: tcs_pkg::RANGE_W],
        data[tcs_pkg::RANGE1_OFF +: tcs_pkg::RANGE_W],
        mask[tcs_pkg::RANGE1_OFF +: tcs_pkg::RANGE_W]);
    end
    return ok;
  endfunction

  // =====================================================
  // Entry storage
  // Both storage kinds share one array; the kind only sets update occupancy
  logic [tcs_pkg::KEY_W-1:0] ent_data_q [tcs_pkg::DEPTH];
  logic [tcs_pkg::KEY_W-1:0] ent_mask_q [tcs_pkg::DEPTH];
  logic [tcs_pkg::VAL_W-1:0] ent_value_q [tcs_pkg::DEPTH];
  logic [tcs_pkg::DEPTH-1:0] ent_en_q;

  // Update controller state
  tcs_pkg::tcs_upd_state_t upd_state_q;
  logic [tcs_pkg::UPD_CNT_W-1:0] upd_cnt_q;
  logic cmd_write_q;
  logic [tcs_pkg::IDX_W-1:0] cmd_index_q;
  logic cmd_enable_q;
  logic [tcs_pkg::KEY_W-1:0] cmd_data_q;
  logic [tcs_pkg::KEY_W-1:0] cmd_mask_q;
  logic [tcs_pkg::VAL_W-1:0] cmd_value_q;
  logic upd_apply;

  // Queue and pipeline
  logic q_valid;
  logic q_ready;
  logic [tcs_pkg::KEY_W-1:0] q_key;
  logic s1_valid_q;
  logic [tcs_pkg::KEY_W-1:0] s1_key_q;
  logic [tcs_pkg::DEPTH-1:0] s1_vec_q;
  logic [tcs_pkg::DEPTH-1:0] hit_vec;
  logic pri_hit;
  logic [tcs_pkg::IDX_W-1:0] pri_idx;

  // =====================================================
  // Request FIFO
  // Its ready stalls the requester, so a long update cannot overflow it
  tcs_fifo #(
    .WIDTH(tcs_pkg::KEY_W),
    .DEPTH(tcs_pkg::FIFO_DEPTH)
  ) u_req_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(search_request_strobe_i),
    .in_ready_o(search_request_ready_o),
    .in_data_i(search_request_key_i),
    .out_valid_o(q_valid),
    .out_ready_i(q_ready),
    .out_data_o(q_key)
  );

  // Dequeue runs except while the database is occupied
  assign q_ready = (upd_state_q != tcs_pkg::UPD_BUSY);

  // =====================================================
  // Match stage: every entry against the dequeued key
  always_comb
  begin
    for (int i = 0; i < tcs_pkg::DEPTH; i++)
    begin
      hit_vec[i] = ent_en_q[i] && entry_hit(q_key, ent_data_q[i], ent_mask_q[i]);
    end
  end

  // Stage one registers; no new key enters while the database is occupied (UPD_BUSY)
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_valid_q <= 1'b0;
      s1_key_q <= '0;
      s1_vec_q <= '0;
    end
    else
    begin
      s1_valid_q <= q_valid && q_ready;
      s1_key_q <= q_key;
      s1_vec_q <= hit_vec;
    end
  end

  // =====================================================
  // Priority stage: scan downward so the lowest index is last written
  always_comb
  begin
    pri_hit = 1'b0;
    pri_idx = '0;
    for (int i = tcs_pkg::DEPTH - 1; i >= 0; i--)
    begin
      if (s1_vec_q[i])
      begin
        pri_hit = 1'b1;
        pri_idx = tcs_pkg::IDX_W'(i);
      end
    end
  end

  // Result registers; a single in-order pipe keeps request order
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      search_result_strobe_o <= 1'b0;
      search_hit_flag_o <= 1'b0;
      search_result_key_copy_o <= '0;
      search_hit_index_o <= '0;
      search_hit_payload_o <= '0;
    end
    else
    begin
      search_result_strobe_o <= s1_valid_q;
      search_hit_flag_o <= s1_valid_q && pri_hit;
      search_result_key_copy_o <= s1_key_q;
      search_hit_index_o <= pri_idx;
      search_hit_payload_o <= ent_value_q[pri_idx];
    end
  end

  // =====================================================
  // Update controller
  // Last busy cycle carries the actual entry access
  assign upd_apply = (upd_state_q == tcs_pkg::UPD_BUSY) && (upd_cnt_q == tcs_pkg::UPD_LAST);

  // Sequencing: accept, drain, occupy, release
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      upd_state_q <= tcs_pkg::UPD_IDLE;
      upd_cnt_q <= '0;
      upd_busy_o <= 1'b0;
      upd_done_o <= 1'b0;
    end
    else
    begin
      upd_done_o <= 1'b0;
      case (upd_state_q)
        tcs_pkg::UPD_IDLE:
        begin
          if (upd_req_i)
          begin
            upd_state_q <= tcs_pkg::UPD_DRAIN;
            upd_busy_o <= 1'b1;
          end
        end
        tcs_pkg::UPD_DRAIN:
        begin
          // Queue and match stage must be empty before occupying
          if (!q_valid && !s1_valid_q)
          begin
            upd_state_q <= tcs_pkg::UPD_BUSY;
            upd_cnt_q <= '0;
          end
        end
        tcs_pkg::UPD_BUSY:
        begin
          if (upd_apply)
          begin
            upd_state_q <= tcs_pkg::UPD_IDLE;
            upd_busy_o <= 1'b0;
            upd_done_o <= 1'b1;
          end
          else
          begin
            upd_cnt_q <= upd_cnt_q + 1'b1;
          end
        end
        default:
        begin
          upd_state_q <= tcs_pkg::UPD_IDLE;
        end
      endcase
    end
  end

  // Command capture; requests while busy are ignored
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cmd_write_q <= 1'b0;
      cmd_index_q <= '0;
      cmd_enable_q <= 1'b0;
      cmd_data_q <= '0;
      cmd_mask_q <= '0;
      cmd_value_q <= '0;
    end
    else if (upd_state_q == tcs_pkg::UPD_IDLE && upd_req_i)
    begin
      cmd_write_q <= upd_write_i;
      cmd_index_q <= upd_index_i;
      cmd_enable_q <= upd_enable_i;
      cmd_data_q <= upd_data_i;
      cmd_mask_q <= upd_mask_i;
      cmd_value_q <= upd_value_i;
    end
  end

  // Entry enables; cleared at reset so empty slots never hit
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ent_en_q <= '0;
    end
    else if (upd_apply && cmd_write_q)
    begin
      ent_en_q[cmd_index_q] <= cmd_enable_q;
    end
  end

  // Entry contents, written only while lookups are held off
  always_ff @(posedge clk_i)
  begin
    if (upd_apply && cmd_write_q)
    begin
      ent_data_q[cmd_index_q] <= cmd_data_q;
      ent_mask_q[cmd_index_q] <= cmd_mask_q;
      ent_value_q[cmd_index_q] <= cmd_value_q;
    end
  end

  // Read-back registers, refreshed by a read operation only
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      upd_rd_enable_o <= 1'b0;
      upd_rd_data_o <= '0;
      upd_rd_mask_o <= '0;
      upd_rd_value_o <= '0;
    end
    else if (upd_apply && !cmd_write_q)
    begin
      upd_rd_enable_o <= ent_en_q[cmd_index_q];
      upd_rd_data_o <= ent_data_q[cmd_index_q];
      upd_rd_mask_o <= ent_mask_q[cmd_index_q];
      upd_rd_value_o <= ent_value_q[cmd_index_q];
    end
  end
endmodule
`default_nettype wire

// ---- tcs_search_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========
// Port checks
module tcs_search_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic search_request_strobe_i,
  input wire logic search_request_ready_o,
  input wire logic search_result_strobe_o,
  input wire logic search_hit_flag_o,
  input wire logic upd_req_i,
  input wire logic upd_busy_o,
  input wire logic upd_done_o
);
  logic [5:0] pend_q;
  logic [9:0] run_q;
  wire take = search_request_strobe_i && search_request_ready_o;
  // Lookups taken, not yet answered
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pend_q <= 6'h00;
    else
      pend_q <= pend_q + 6'(take) - 6'(search_result_strobe_o);
  end
  // Busy length; drain cycles count too, so a floor only
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !upd_busy_o)
      run_q <= 10'h000;
    else
      run_q <= run_q + 10'h001;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_idle_take;
    take && pend_q == 6'h00 && !upd_busy_o;
  endsequence
  // Queue, match and result registers each add an edge
  sequence s_answer;
    !search_result_strobe_o ##1 !search_result_strobe_o ##1 search_result_strobe_o;
  endsequence
  property p_idle_latency;
    s_idle_take |=> s_answer;
  endproperty
  a_idle_latency: assert property (p_idle_latency)
    else $error("idle lookup late");
  property p_hit_gate;
    search_hit_flag_o |-> search_result_strobe_o;
  endproperty
  a_hit_gate: assert property (p_hit_gate)
    else $error("hit without strobe");
  property p_paired;
    search_result_strobe_o |-> pend_q != 6'h00;
  endproperty
  a_paired: assert property (p_paired)
    else $error("result without request");
  property p_upd_take;
    upd_req_i && !upd_busy_o |=> upd_busy_o;
  endproperty
  a_upd_take: assert property (p_upd_take)
    else $error("update not taken");
  property p_upd_len;
    upd_done_o |-> $fell(upd_busy_o) && run_q >= 10'h022;
  endproperty
  a_upd_len: assert property (p_upd_len)
    else $error("update too short");
  property p_resume;
    upd_done_o && pend_q != 6'h00 |-> ##[1:4] search_result_strobe_o;
  endproperty
  a_resume: assert property (p_resume)
    else $error("dequeue not resumed");
  property p_ready_back;
    $fell(rst_i) |=> search_request_ready_o;
  endproperty
  a_ready_back: assert property (p_ready_back)
    else $error("ready missing after reset");
  property p_refuse_full;
    !search_request_ready_o && !$fell(rst_i) |-> pend_q >= 6'h10;
  endproperty
  a_refuse_full: assert property (p_refuse_full)
    else $error("refused with room");
endmodule
bind tcs_search tcs_search_asserts tcs_search_asserts_inst (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .search_request_strobe_i(search_request_strobe_i),
  .search_request_ready_o(search_request_ready_o),
  .search_result_strobe_o(search_result_strobe_o),
  .search_hit_flag_o(search_hit_flag_o),
  .upd_req_i(upd_req_i),
  .upd_busy_o(upd_busy_o),
  .upd_done_o(upd_done_o)
);
`default_nettype wire

// ---- tcs_requester.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========
// Packet-side requester
module tcs_requester (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic push_i,
  input wire logic [tcs_pkg::KEY_W-1:0] push_key_i,
  input wire logic ready_i,
  output logic strobe_o,
  output logic [tcs_pkg::KEY_W-1:0] key_o
);
  logic [tcs_pkg::KEY_W-1:0] keys_q [$];
  initial strobe_o = 1'b0;
  initial key_o = '0;
  // Hold key until taken; idle key toggles so stale data never looks valid
  always @(posedge clk_i)
  begin
    if (rst_i)
      keys_q.delete();
    else if (strobe_o && ready_i)
      void'(keys_q.pop_front());
    if (push_i && !rst_i)
      keys_q.push_back(push_key_i);
    strobe_o <= keys_q.size() != 0;
    key_o <= keys_q.size() != 0 ? keys_q[0] : ~key_o;
  end
endmodule
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========
// Self-checking bench
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic push_i = 1'b0;
  logic [tcs_pkg::KEY_W-1:0] push_key_i = '0;
  logic search_request_strobe_i, search_request_ready_o, search_result_strobe_o, search_hit_flag_o;
  logic [tcs_pkg::KEY_W-1:0] search_request_key_i, search_result_key_copy_o, upd_rd_data_o, upd_rd_mask_o;
  logic [tcs_pkg::IDX_W-1:0] search_hit_index_o;
  logic [tcs_pkg::VAL_W-1:0] search_hit_payload_o, upd_rd_value_o;
  logic upd_req_i = 1'b0;
  logic upd_write_i = 1'b0;
  logic upd_enable_i = 1'b0;
  logic [tcs_pkg::IDX_W-1:0] upd_index_i = '0;
  logic [tcs_pkg::KEY_W-1:0] upd_data_i = '0;
  logic [tcs_pkg::KEY_W-1:0] upd_mask_i = '0;
  logic [tcs_pkg::VAL_W-1:0] upd_value_i = '0;
  logic upd_busy_o, upd_done_o, upd_rd_enable_o;
  logic [60:0] exp_q [$];
  logic [60:0] rows [8];
  int error_cnt = 0;
  int check_count = 0;
  int refused = 0;
  int n;
  tcs_search tcs_search_inst (.clk_i, .rst_i, .search_request_strobe_i, .search_request_key_i,
    .search_request_ready_o, .search_result_strobe_o, .search_hit_flag_o, .search_result_key_copy_o,
    .search_hit_index_o, .search_hit_payload_o, .upd_req_i, .upd_write_i, .upd_index_i, .upd_enable_i,
    .upd_data_i, .upd_mask_i, .upd_value_i, .upd_busy_o, .upd_done_o, .upd_rd_enable_o, .upd_rd_data_o,
    .upd_rd_mask_o, .upd_rd_value_o);
  tcs_requester tcs_requester_inst (.clk_i, .rst_i, .push_i, .push_key_i, .ready_i(search_request_ready_o),
    .strobe_o(search_request_strobe_i), .key_o(search_request_key_i));
  always #20 clk_i = ~clk_i;
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk_res(input logic [60:0] got, input logic [60:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %0t result %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_val(input logic [96:0] got, input logic [96:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %0t value %h want %h", $time, got, exp);
    end
  endtask
  task automatic guard(input int k);
    @(negedge clk_i);
    if (k > 2000)
    begin
      error_cnt++;
      $display("unexpected %0t wait ran out", $time);
      test_done();
    end
  endtask
  // Results compared in request order; refusals counted
  always @(posedge clk_i)
  begin
    if (search_request_strobe_i === 1'b1 && search_request_ready_o === 1'b0)
      refused++;
    if (search_result_strobe_o === 1'b1)
      chk_res({search_hit_flag_o, search_hit_flag_o ? {search_hit_index_o, search_hit_payload_o} : 20'h00000,
        search_result_key_copy_o}, exp_q.size() != 0 ? exp_q.pop_front() : 61'h0);
  end
  task automatic upd(input logic wr, input logic [3:0] idx, input logic en, input logic [39:0] d,
    input logic [39:0] m, input logic [15:0] v);
    int k;
    @(posedge clk_i);
    upd_req_i <= 1'b1;
    upd_write_i <= wr;
    upd_index_i <= idx;
    upd_enable_i <= en;
    upd_data_i <= d;
    upd_mask_i <= m;
    upd_value_i <= v;
    @(posedge clk_i);
    upd_req_i <= 1'b0;
    for (k = 0; upd_done_o !== 1'b1; k++)
      guard(k);
  endtask
  task automatic look(input logic [60:0] r);
    @(posedge clk_i);
    push_i <= 1'b1;
    push_key_i <= r[39:0];
    exp_q.push_back(r);
  endtask
  // Stop pushing, then wait until every result is in
  task automatic settle();
    int k;
    @(posedge clk_i);
    push_i <= 1'b0;
    for (k = 0; exp_q.size() != 0; k++)
      guard(k);
  endtask
  // Main sequence
  initial
  begin
    rows = '{{1'b1, 4'h1, 16'h00A1, 40'h1234561577}, {1'b1, 4'h4, 16'h00B4, 40'h1234562177},
      {1'b1, 4'h1, 16'h00A1, 40'h1234561000}, {1'b1, 4'h4, 16'h00B4, 40'h1234560F00},
      {1'b1, 4'h1, 16'h00A1, 40'h12345620FF}, {1'b1, 4'h4, 16'h00B4, 40'h1299002000},
      {1'b0, 4'h0, 16'h0000, 40'h3300000000}, {1'b0, 4'h0, 16'h0000, 40'h12000000F0}};
    repeat (9) @(posedge clk_i);
    @(negedge clk_i);
    chk_val(97'({search_request_ready_o, search_result_strobe_o, upd_busy_o, upd_done_o}), 97'h0);
    @(posedge clk_i);
    rst_i <= 1'b0;
    look({1'b0, 4'h0, 16'h0000, 40'h1234561577});
    settle();
    upd(1'b1, 4'h1, 1'b1, 40'h1234001000, 40'hFFFF0020FF, 16'h00A1);
    upd(1'b1, 4'h4, 1'b1, 40'h1200000000, 40'hFF0000FF7F, 16'h00B4);
    upd(1'b0, 4'h1, 1'b0, 40'h0, 40'h0, 16'h0);
    chk_val({upd_rd_enable_o, upd_rd_data_o, upd_rd_mask_o, upd_rd_value_o},
      {1'b1, 40'h1234001000, 40'hFFFF0020FF, 16'h00A1});
    foreach (rows[r])
      look(rows[r]);
    settle();
    fork
      upd(1'b1, 4'h7, 1'b0, 40'h0, 40'h0, 16'h0);
      begin
        repeat (4) @(posedge clk_i);
        for (n = 0; n < 20; n++)
          look({1'b1, 4'h4, 16'h00B4, 32'h12000000, 8'(n)});
        settle();
      end
    join
    chk_val(97'(refused != 0), 97'h1);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    look({1'b0, 4'h0, 16'h0000, 40'h1234561577});
    settle();
    test_done();
  end
endmodule
`default_nettype wire
